// ===== common/drc_defines.svh
/*
 * Offsets, field positions, codes and reset values of the channel
 * request control block. Assumes inclusion by bare name.
 */
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

`define DRC_OFF_CTRL      4'h0
`define DRC_OFF_MODE      4'h4
`define DRC_OFF_STAT      4'h8

`define DRC_SRC_LSB       0
`define DRC_SRC_MSB       3
`define DRC_SENSE_BIT     4
`define DRC_ACK_EN_BIT    5
`define DRC_CTRL_MASK     8'h3F
`define DRC_CTRL_RESET    8'h00
`define DRC_UNDEF_FILL    2'h0

`define DRC_SRC_NONE      4'h0
`define DRC_SRC_EXT       4'h1
`define DRC_SRC_SOFT      4'h2
`define DRC_SRC_TA0       4'h3
`define DRC_SRC_TA4       4'h7
`define DRC_SRC_TB0       4'h8
`define DRC_SRC_TB2       4'hA
`define DRC_SRC_U0RX      4'hB
`define DRC_SRC_U0TX      4'hC
`define DRC_SRC_U1RX      4'hD
`define DRC_SRC_U1TX      4'hE
`define DRC_SRC_ADC       4'hF

`endif

// ===== common/drc_pkg.sv
/*
 * Types of the channel request control block.
 * Assumes drc_defines.svh for numeric values.
 */
package drc_pkg;
  typedef struct packed {
    logic       ack_en;
    logic       level_sense;
    logic [3:0] source;
  } drc_ctrl_t;

  typedef struct packed {
    logic       adc_done;
    logic [1:0] uart_tx;
    logic [1:0] uart_rx;
    logic [2:0] timer_b;
    logic [4:0] timer_a;
  } drc_events_t;
endpackage

// ===== tb/dma_channel_request_control_tb_top.sv
/*
 * Self-checking bench of the channel request control block.
 * Assumes drc_pkg and the request pin model compiled first.
 */
module dma_channel_request_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [3:0]           addr = 4'h0;
  logic                 rd = 1'b0;
  logic                 wr = 1'b0;
  logic [31:0]          wdata = 32'h0000_0000;
  logic [31:0]          rdata;
  logic [31:0]          r;
  logic                 waitreq;
  logic                 pin_n;
  logic                 chack = 1'b0;
  logic                 pout = 1'b1;
  logic                 poe = 1'b0;
  logic                 treq;
  logic                 ack_o;
  logic                 ack_oe;
  int                   c;
  int                   e;
  int                   mismatches = 0;
  int                   samples_checked = 0;
  drc_pkg::drc_events_t ev = '0;

  drc_req_model peer (.clk(clk), .pin_n(pin_n));
  drc_top dut (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .EXTERNAL_TRANSFER_REQUEST_PIN_N(pin_n),
    .EVENTS(ev), .CHANNEL_ACK(chack), .PORT_OUT(pout), .PORT_OE(poe),
    .TRANSFER_REQUEST(treq), .TRANSFER_ACKNOWLEDGE_PIN_O(ack_o),
    .TRANSFER_ACKNOWLEDGE_PIN_OE(ack_oe));

  initial forever #5 clk = ~clk;

  // Event vector position of each on-chip source code
  function automatic int ev_bit(input int s);
    case (s)
      11: return 8;
      12: return 10;
      13: return 9;
      14: return 11;
      15: return 12;
      default: return s - 3;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 64) mismatches++;
  endtask

  task automatic count(input int k);
    c = 0;
    repeat (k) begin
      @(posedge clk);
      c += int'(treq === 1'b1);
    end
  endtask

  task automatic fire(input int b);
    @(posedge clk);
    ev <= drc_pkg::drc_events_t'(13'h1 << b);
    @(posedge clk);
    ev <= '0;
    count(8);
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hf049));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(0, 4'h0, 8'h00);
    chk(r, 32'h0000_0000);
    bus(0, 4'hC, 8'h00);
    chk(r, 32'h0000_0000);
    repeat (6) begin
      e = $urandom;
      bus(1, 4'h0, 8'(e));
      bus(0, 4'h0, 8'h00);
      chk(r, {26'h0, 6'(e)});
    end
    $display("test registers done");
    for (int s = 3; s < 16; s++) begin
      bus(1, 4'h0, 8'(s));
      fire((ev_bit(s) + 1 + int'($urandom % 12)) % 13);
      chk(c, 0);
      fire(ev_bit(s));
      chk(c, 1);
    end
    $display("test sources done");
    bus(1, 4'h0, 8'h00);
    for (int b = 0; b < 13; b++) begin
      fire(b);
      chk(c, 0);
    end
    fork peer.drop(3); count(16); join
    chk(c, 0);
    bus(1, 4'h0, 8'h01);
    fork peer.drop(3); count(16); join
    chk(c, 1);
    bus(1, 4'h0, 8'h02);
    bus(1, 4'h8, 8'h01);
    count(4);
    chk(c != 0, 1'b1);
    chack <= 1'b1;
    @(posedge clk);
    chack <= 1'b0;
    bus(0, 4'h8, 8'h00);
    chk(r, 32'h0000_0002);
    $display("test request kinds done");
    bus(1, 4'h4, 8'h01);
    bus(0, 4'h4, 8'h00);
    chk(r, 32'h0000_0001);
    bus(1, 4'h0, 8'h11);
    fork peer.drop(12); count(24); join
    chk(c > 4, 1'b1);
    // Level bit in cycle steal is stored but must act as edge sense
    bus(1, 4'h4, 8'h00);
    fork peer.drop(12); count(24); join
    chk(c, 1);
    $display("test sensing done");
    bus(1, 4'h0, 8'h20);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) bus(1, 4'h0, 8'h00);
      e = $urandom;
      @(posedge clk);
      chack <= e[0];
      pout <= e[1];
      poe <= e[2];
      repeat (3) @(posedge clk);
      chk({ack_oe, ack_o}, i < 4 ? {1'b1, ~e[0]} : e[2:1]);
    end
    $display("test acknowledge pin done");
    give_verdict();
  end
endmodule

// ===== tb/drc_req_model.sv
/*
 * Peripheral that drives the active-low external request pin.
 * Assumes the bench clock; the pin idles high as with a pull-up.
 */
module drc_req_model (
  // Clock
  input  wire logic clk,
  // Request pin
  output logic      pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_n = 1'b1;
  // Released pin returns to the pull-up level, never to a stale value
  task automatic drop(input int hold);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (hold) @(posedge clk);
    pin_n <= 1'b1;
  endtask
endmodule

// ===== verilog/drc_sync.sv
/*
 * Three-stage pin synchroniser; a change counts once stages two and
 * three agree. Assumes a single clock with synchronous reset.
 */
module drc_sync (
  // Clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RST,
  // Pin and result
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sh_q;
  logic       lvl_q;
  wire logic  agree = (sh_q[1] == sh_q[2]);

  // Reset value is high: the request pin idles high
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sh_q  <= 3'h7;
      lvl_q <= 1'b1;
    end else begin
      sh_q  <= {sh_q[1:0], pin_i};
      if (agree)
        lvl_q <= sh_q[2];
    end
  end

  assign level_o = lvl_q;
endmodule

// ===== verilog/drc_top.sv
/*
 * Request control of one DMA channel: control register, request source
 * selection, external request sensing and acknowledge pin enable.
 * Assumes an Avalon-MM master on CORE_CLK and peripheral event pulses
 * from logic on the same clock.
 */
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`include "drc_defines.svh"

module drc_top (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Request sources
  input  wire logic        EXTERNAL_TRANSFER_REQUEST_PIN_N,
  input  drc_pkg::drc_events_t EVENTS,
  // Channel side
  input  wire logic        CHANNEL_ACK,
  input  wire logic        PORT_OUT,
  input  wire logic        PORT_OE,
  output logic             TRANSFER_REQUEST,
  output logic             TRANSFER_ACKNOWLEDGE_PIN_O,
  output logic             TRANSFER_ACKNOWLEDGE_PIN_OE
);
  drc_pkg::drc_ctrl_t ctrl_q;
  logic               burst_q;
  logic               soft_q;
  logic               ack_phase_q;
  logic               wait_q;
  logic               ext_prev_q;
  logic               req_q;
  logic [31:0]        rdata_q;
  logic               ack_o_q;
  logic               ack_oe_q;
  logic               ext_lvl;

  drc_sync u_sync (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .pin_i    (EXTERNAL_TRANSFER_REQUEST_PIN_N),
    .level_o  (ext_lvl)
  );

  function automatic logic sel_bit(input logic [3:0] a, input logic [3:0] b);
    sel_bit = (a == b);
  endfunction

  // Bus decode: one wait cycle, answer on the second edge
  wire logic access    = AVS_READ | AVS_WRITE;
  wire logic accept    = access & ack_phase_q;
  wire logic wr_lane0  = accept & AVS_WRITE & AVS_BYTEENABLE[0];
  wire logic hit_ctrl  = sel_bit(AVS_ADDRESS, `DRC_OFF_CTRL);
  wire logic hit_mode  = sel_bit(AVS_ADDRESS, `DRC_OFF_MODE);
  wire logic hit_stat  = sel_bit(AVS_ADDRESS, `DRC_OFF_STAT);
  wire logic wr_ctrl   = wr_lane0 & hit_ctrl;
  wire logic wr_mode   = wr_lane0 & hit_mode;
  wire logic [7:0] wd  = AVS_WRITEDATA[7:0];

  // Level sense is honoured only in this legal combination
  wire logic ext_sel   = sel_bit(ctrl_q.source, `DRC_SRC_EXT);
  wire logic lvl_ok    = ctrl_q.level_sense & ext_sel & burst_q;
  wire logic ext_fall  = ext_prev_q & ~ext_lvl;
  wire logic ext_req   = lvl_ok ? ~ext_lvl : ext_fall;

  // Source selection; code 0 never requests
  wire logic [3:0] src = ctrl_q.source;
  wire logic [3:0] ta_i = src - `DRC_SRC_TA0;
  wire logic [3:0] tb_i = src - `DRC_SRC_TB0;
  wire logic in_ta = (src >= `DRC_SRC_TA0) & (src <= `DRC_SRC_TA4);
  wire logic in_tb = (src >= `DRC_SRC_TB0) & (src <= `DRC_SRC_TB2);
  wire logic peri_req =
      (in_ta & EVENTS.timer_a[ta_i[2:0]])
    | (in_tb & EVENTS.timer_b[tb_i[1:0]])
    | (sel_bit(src, `DRC_SRC_U0RX) & EVENTS.uart_rx[0])
    | (sel_bit(src, `DRC_SRC_U0TX) & EVENTS.uart_tx[0])
    | (sel_bit(src, `DRC_SRC_U1RX) & EVENTS.uart_rx[1])
    | (sel_bit(src, `DRC_SRC_U1TX) & EVENTS.uart_tx[1])
    | (sel_bit(src, `DRC_SRC_ADC)  & EVENTS.adc_done);
  wire logic soft_sel = sel_bit(src, `DRC_SRC_SOFT);
  wire logic req_d = (ext_sel & ext_req) | (soft_sel & soft_q)
                   | peri_req;

  wire logic [31:0] rd_d =
      hit_ctrl ? {24'h00_0000, `DRC_UNDEF_FILL, ctrl_q} :
      hit_mode ? {31'h0000_0000, burst_q} :
      hit_stat ? {29'h0000_0000, req_q, ext_lvl, soft_q} :
                 32'h0000_0000;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_q      <= drc_pkg::drc_ctrl_t'(6'(`DRC_CTRL_RESET));
      burst_q     <= 1'b0;
      ack_phase_q <= 1'b0;
      wait_q      <= 1'b1;
      rdata_q     <= 32'h0000_0000;
    end else begin
      ack_phase_q <= access & ~ack_phase_q;
      // Registered copy of the inverted phase keeps the pin glitch free
      wait_q      <= ~(access & ~ack_phase_q);
      if (wr_ctrl)
        ctrl_q <= drc_pkg::drc_ctrl_t'(wd[5:0]);
      if (wr_mode)
        burst_q <= wd[0];
      if (access & ~ack_phase_q)
        rdata_q <= rd_d;
    end
  end

  // Software request: writing 1 to status bit 0 sets it; the
  // channel acknowledge clears it while the software source is selected, but a new set wins
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      soft_q <= 1'b0;
    else if (accept & AVS_WRITE & hit_stat & AVS_BYTEENABLE[0] & wd[0])
      soft_q <= 1'b1;
    else if (CHANNEL_ACK & soft_sel)
      soft_q <= 1'b0;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ext_prev_q <= 1'b1;
      req_q      <= 1'b0;
      ack_o_q    <= 1'b1;
      ack_oe_q   <= 1'b0;
    end else begin
      ext_prev_q <= ext_lvl;
      req_q      <= req_d;
      // Acknowledge is active low on the pin
      ack_o_q    <= ctrl_q.ack_en ? ~CHANNEL_ACK : PORT_OUT;
      ack_oe_q   <= ctrl_q.ack_en | PORT_OE;
    end
  end

  assign AVS_WAITREQUEST             = wait_q;
  assign AVS_READDATA                = rdata_q;
  assign TRANSFER_REQUEST            = req_q;
  assign TRANSFER_ACKNOWLEDGE_PIN_O  = ack_o_q;
  assign TRANSFER_ACKNOWLEDGE_PIN_OE = ack_oe_q;

  AST_RESET_CLEARS_CTRL: assert property (@(posedge CORE_CLK)
    RST |=> ctrl_q == drc_pkg::drc_ctrl_t'(6'(`DRC_CTRL_RESET)))
    else $error("control not cleared by reset");
  AST_NONE_NO_REQ: assert property (@(posedge CORE_CLK) disable iff (RST)
    sel_bit(src, `DRC_SRC_NONE) && $stable(src) |=> !req_q)
    else $error("request with no source selected");
  AST_SOFT_REQ: assert property (@(posedge CORE_CLK) disable iff (RST)
    soft_sel && soft_q |=> req_q)
    else $error("software request not raised");
  AST_ADC_REQ: assert property (@(posedge CORE_CLK) disable iff (RST)
    sel_bit(src, `DRC_SRC_ADC) && EVENTS.adc_done |=> req_q)
    else $error("converter request missed");
  AST_TIMER_A_ONLY: assert property (@(posedge CORE_CLK) disable iff (RST)
    in_ta && !EVENTS.timer_a[ta_i[2:0]] |=> !req_q)
    else $error("timer request without its event");
  AST_EDGE_SENSE: assert property (@(posedge CORE_CLK) disable iff (RST)
    ext_sel && !lvl_ok && ext_prev_q && !ext_lvl |=> req_q)
    else $error("falling edge not seen");
  AST_EDGE_ONCE: assert property (@(posedge CORE_CLK) disable iff (RST)
    ext_sel && !lvl_ok && !ext_prev_q && !ext_lvl |=> !req_q)
    else $error("edge mode repeats on a held level");
  AST_LEVEL_NEEDS_BURST: assert property (@(posedge CORE_CLK)
    disable iff (RST)
    ext_sel && !burst_q && !ext_lvl && !ext_prev_q |=> !req_q)
    else $error("level sensing outside burst mode");
  AST_ACK_PIN: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctrl_q.ack_en |=> TRANSFER_ACKNOWLEDGE_PIN_OE
      && TRANSFER_ACKNOWLEDGE_PIN_O == !$past(CHANNEL_ACK))
    else $error("acknowledge pin not driven");
  AST_WAIT_ONE: assert property (@(posedge CORE_CLK) disable iff (RST)
    access && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
endmodule
